// *** src/ftc_mode_ctrl.sv ***
/*
  Mode, wake-up and termination control of a fault-tolerant low-speed CAN
  transceiver, with a classic Wishbone register slave.
  Assumes all inputs synchronous to i_clk_sys; the failure class comes from
  an external detector, bus dominance from external comparators.

*/
// Added by the designer: the register addresses and register access over Wishbone.
`timescale 1ns/10ps
module ftc_mode_ctrl (
	// clock and reset
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst,
	// wishbone slave
	input  wire logic        i_wb_cyc,
	input  wire logic        i_wb_stb,
	input  wire logic        i_wb_we,
	input  wire logic [3:0]  i_wb_adr,
	input  wire logic [3:0]  i_wb_sel,
	input  wire logic [31:0] i_wb_dat,
	output logic      [31:0] o_wb_dat,
	output logic             o_wb_ack,
	// host mode pins
	input  wire logic        i_power_mode_select,
	input  wire logic        i_enable,
	// analog front end status
	input  wire logic        i_vcc_ok,
	input  wire logic        i_battery_por,
	input  wire logic        i_canh_dom,
	input  wire logic        i_canl_dom,
	input  wire logic        i_local_wake_n,
	input  wire logic        i_rx_data,
	input  wire logic [3:0]  i_fail_class,
	input  wire logic        i_diff_restored,
	// host outputs
	output logic             o_rx_data,
	output logic             o_fault_wake_flag_n,
	// regulator inhibit
	output logic             o_regulator_inhibit_out,
	output logic             o_regulator_inhibit_oe_n,
	// terminations, drivers and low-power failure detection
	output logic             o_high_term_on,
	output logic             o_low_term_on,
	output logic             o_low_term_to_batt,
	output logic             o_low_term_pullup_current_on,
	output logic             o_high_term_pd_sw,
	output logic             o_low_term_pu_sw,
	output logic             o_canh_drv_en,
	output logic             o_canl_drv_en,
	output logic             o_lp_fail_detect_en
);

	// ------------------------------------------------------------
	// wake filters
	// ------------------------------------------------------------
	logic       lp_mode;
	logic       local_en_r;
	logic       bus_en_r;
	logic [2:0] wake_hit;
	logic       wake_any;

	ftc_wake_filt u_wake_canh (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_level   (i_canh_dom),
		.i_enable  (lp_mode & bus_en_r),
		.o_wake    (wake_hit[0])
	);

	ftc_wake_filt u_wake_canl (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_level   (i_canl_dom),
		.i_enable  (lp_mode & bus_en_r),
		.o_wake    (wake_hit[1])
	);

	ftc_wake_filt u_wake_local (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_level   (~i_local_wake_n),
		.i_enable  (lp_mode & local_en_r),
		.o_wake    (wake_hit[2])
	);

	assign wake_any = |wake_hit;

	// ------------------------------------------------------------
	// mode state and flags
	// ------------------------------------------------------------
	ftc_pkg::ftc_mode_e mode_r;
	ftc_pkg::ftc_mode_e mode_nxt;
	logic               inh_r;
	logic               inh_nxt;
	logic               wake_pend_r;
	logic               wake_pend_nxt;
	logic               por_r;
	logic               por_nxt;
	logic               hold_h_r;
	logic               hold_h_nxt;
	logic               por_clr;

	assign lp_mode = (mode_r != ftc_pkg::MODE_NORMAL);

	always_comb begin
		mode_nxt = mode_r;
		inh_nxt  = inh_r;
		case ({i_power_mode_select, i_enable})
			2'h3: begin
				mode_nxt = ftc_pkg::MODE_NORMAL;
				inh_nxt  = 1'b1;
			end
			2'h2: begin
				mode_nxt = ftc_pkg::MODE_POR_STANDBY;
				if (mode_r == ftc_pkg::MODE_STANDBY) begin
					inh_nxt = 1'b1;
				end else if (mode_r == ftc_pkg::MODE_SLEEP) begin
					inh_nxt = 1'b0;
				end
			end
			2'h1: begin
				mode_nxt = ftc_pkg::MODE_GOTO_SLEEP;
			end
			default: begin
				// sleep only when the go-to-sleep command came first
				if (mode_r == ftc_pkg::MODE_GOTO_SLEEP || mode_r == ftc_pkg::MODE_SLEEP) begin
					mode_nxt = ftc_pkg::MODE_SLEEP;
					inh_nxt  = 1'b0;
				end else begin
					mode_nxt = ftc_pkg::MODE_STANDBY;
					inh_nxt  = 1'b1;
				end
			end
		endcase
		// an accepted wake leaves sleep for standby
		if (wake_any) begin
			inh_nxt = 1'b1;
			if (mode_nxt == ftc_pkg::MODE_SLEEP) begin
				mode_nxt = ftc_pkg::MODE_STANDBY;
			end
		end
	end

	always_comb begin
		wake_pend_nxt = wake_pend_r;
		if (mode_nxt == ftc_pkg::MODE_NORMAL && mode_r != ftc_pkg::MODE_NORMAL) begin
			wake_pend_nxt = 1'b0;
		end
		// set wins over clear
		if (wake_any) begin
			wake_pend_nxt = 1'b1;
		end
		por_nxt = por_r;
		if (por_clr) begin
			por_nxt = 1'b0;
		end
		if (i_battery_por) begin
			por_nxt = 1'b1;
		end
		hold_h_nxt = hold_h_r;
		if (i_fail_class == ftc_pkg::FAIL_CANH_VCC) begin
			hold_h_nxt = 1'b1;
		end else if (i_diff_restored) begin
			hold_h_nxt = 1'b0;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			mode_r      <= ftc_pkg::MODE_STANDBY;
			inh_r       <= 1'b1;
			wake_pend_r <= 1'b0;
			por_r       <= 1'b1;
			hold_h_r    <= 1'b0;
		end else begin
			mode_r      <= mode_nxt;
			inh_r       <= inh_nxt;
			wake_pend_r <= wake_pend_nxt;
			por_r       <= por_nxt;
			hold_h_r    <= hold_h_nxt;
		end
	end

	// ------------------------------------------------------------
	// pin outputs
	// ------------------------------------------------------------
	logic [12:0] pin_r;
	logic [12:0] pin_nxt;
	logic        rx_n;
	logic        err_n;
	logic        hterm;
	logic        lterm;
	logic        lpull;
	logic        h_drv;
	logic        l_drv;
	logic        h_fault;
	logic        l_fault;

	always_comb begin
		// classes 3, 4, 7, 8 stay watched in every mode
		h_fault = (i_fail_class == ftc_pkg::FAIL_CANH_BATT)
			| (i_fail_class == ftc_pkg::FAIL_CANH_VCC);
		l_fault = (i_fail_class == ftc_pkg::FAIL_CANL_GND)
			| (i_fail_class == ftc_pkg::FAIL_CANL_CANH);
		if (mode_r == ftc_pkg::MODE_NORMAL) begin
			// classes 1, 2, 5, 9 leave everything on
			hterm = ~h_fault;
			lterm = ~l_fault & (i_fail_class != ftc_pkg::FAIL_CANL_BATT);
			lpull = 1'b0;
			h_drv = ~h_fault;
			l_drv = ~l_fault;
			rx_n  = i_rx_data;
			err_n = ~((i_fail_class != ftc_pkg::FAIL_NONE) | hold_h_r);
		end else begin
			// drivers are off whenever the link is not in normal mode
			hterm = ~h_fault;
			lterm = 1'b0;
			lpull = ~l_fault;
			h_drv = 1'b0;
			l_drv = 1'b0;
			// no logic supply: outputs idle high
			rx_n  = ~(wake_pend_r & i_vcc_ok);
			if (mode_r == ftc_pkg::MODE_POR_STANDBY) begin
				err_n = ~(por_r & i_vcc_ok);
			end else begin
				err_n = ~(wake_pend_r & i_vcc_ok);
			end
		end
		pin_nxt = {
			mode_r != ftc_pkg::MODE_SLEEP,
			mode_r != ftc_pkg::MODE_SLEEP,
			lp_mode,
			lp_mode,
			~inh_nxt,
			inh_nxt,
			err_n,
			rx_n,
			hterm,
			lterm,
			lpull,
			h_drv,
			l_drv
		};
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			pin_r <= 13'h1EE0;
		end else begin
			pin_r <= pin_nxt;
		end
	end

	assign o_high_term_pd_sw            = pin_r[12];
	assign o_low_term_pu_sw             = pin_r[11];
	assign o_lp_fail_detect_en          = pin_r[10];
	assign o_low_term_to_batt           = pin_r[9];
	assign o_regulator_inhibit_oe_n     = pin_r[8];
	assign o_regulator_inhibit_out      = pin_r[7];
	assign o_fault_wake_flag_n          = pin_r[6];
	assign o_rx_data                    = pin_r[5];
	assign o_high_term_on               = pin_r[4];
	assign o_low_term_on                = pin_r[3];
	assign o_low_term_pullup_current_on = pin_r[2];
	assign o_canh_drv_en                = pin_r[1];
	assign o_canl_drv_en                = pin_r[0];

	// ------------------------------------------------------------
	// wishbone slave
	// ------------------------------------------------------------
	logic        ack_r;
	logic        ack_nxt;
	logic [31:0] rdat_r;
	logic [31:0] rdat_nxt;
	logic        local_en_nxt;
	logic        bus_en_nxt;
	logic        wr_ctrl;
	logic        req;

	// one wait state: ack one cycle after the request, dropped the next
	assign req     = i_wb_cyc & i_wb_stb & ~ack_r;
	assign wr_ctrl = req & i_wb_we & i_wb_sel[0] & (i_wb_adr == ftc_pkg::ADR_CTRL);
	assign por_clr = wr_ctrl & i_wb_dat[ftc_pkg::CTRL_POR_CLR];

	always_comb begin
		ack_nxt      = req;
		local_en_nxt = local_en_r;
		bus_en_nxt   = bus_en_r;
		rdat_nxt     = '0;
		if (wr_ctrl) begin
			local_en_nxt = i_wb_dat[ftc_pkg::CTRL_LOCAL_EN];
			bus_en_nxt   = i_wb_dat[ftc_pkg::CTRL_BUS_EN];
		end
		if (req && !i_wb_we) begin
			case (i_wb_adr)
				ftc_pkg::ADR_CTRL: begin
					rdat_nxt[ftc_pkg::CTRL_LOCAL_EN] = local_en_r;
					rdat_nxt[ftc_pkg::CTRL_BUS_EN]   = bus_en_r;
				end
				ftc_pkg::ADR_STATUS: begin
					rdat_nxt[ftc_pkg::ST_MODE_LSB +: 3] = mode_r;
					rdat_nxt[ftc_pkg::ST_WAKE]          = wake_pend_r;
					rdat_nxt[ftc_pkg::ST_POR]           = por_r;
					rdat_nxt[ftc_pkg::ST_FAIL_LSB +: 4] = i_fail_class;
					rdat_nxt[ftc_pkg::ST_INH]           = inh_r;
					rdat_nxt[ftc_pkg::ST_HOLD_H]        = hold_h_r;
				end
				default: begin
					rdat_nxt = '0;
				end
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			ack_r      <= 1'b0;
			rdat_r     <= '0;
			local_en_r <= ftc_pkg::CTRL_EN_RST[0];
			bus_en_r   <= ftc_pkg::CTRL_EN_RST[1];
		end else begin
			ack_r      <= ack_nxt;
			rdat_r     <= rdat_nxt;
			local_en_r <= local_en_nxt;
			bus_en_r   <= bus_en_nxt;
		end
	end

	assign o_wb_ack = ack_r;
	assign o_wb_dat = rdat_r;

endmodule

// *** src/ftc_pkg.sv ***
/*
  Package for the fault-tolerant CAN mode and wake-up controller: register map,
  field positions, reset values, mode states and timing counts.
  Assumes a 100 MHz system clock.
*/
package ftc_pkg;

	// -------------------------------------------------------------
	// timing
	// -------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int WAKE_MIN_NS   = 38000;
	// least time: round up
	localparam int WAKE_CYC      = (WAKE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WAKE_CW       = 12;

	// -------------------------------------------------------------
	// register map (byte addresses)
	// -------------------------------------------------------------
	localparam logic [3:0] ADR_CTRL   = 4'h0;
	localparam logic [3:0] ADR_STATUS = 4'h4;

	// ctrl fields
	localparam int CTRL_POR_CLR   = 0;
	localparam int CTRL_LOCAL_EN  = 1;
	localparam int CTRL_BUS_EN    = 2;
	localparam logic [1:0] CTRL_EN_RST = 2'h3;

	// status fields
	localparam int ST_MODE_LSB  = 0;
	localparam int ST_WAKE      = 3;
	localparam int ST_POR       = 4;
	localparam int ST_FAIL_LSB  = 5;
	localparam int ST_INH       = 9;
	localparam int ST_HOLD_H    = 10;

	// -------------------------------------------------------------
	// failure classes
	// -------------------------------------------------------------
	localparam logic [3:0] FAIL_NONE      = 4'h0;
	localparam logic [3:0] FAIL_CANH_BATT = 4'h3;
	localparam logic [3:0] FAIL_CANL_GND  = 4'h4;
	localparam logic [3:0] FAIL_CANL_BATT = 4'h6;
	localparam logic [3:0] FAIL_CANL_CANH = 4'h7;
	localparam logic [3:0] FAIL_CANH_VCC  = 4'h8;

	// -------------------------------------------------------------
	// modes
	// -------------------------------------------------------------
	typedef enum logic [2:0] {
		MODE_NORMAL,
		MODE_GOTO_SLEEP,
		MODE_SLEEP,
		MODE_STANDBY,
		MODE_POR_STANDBY
	} ftc_mode_e;

endpackage

// *** src/ftc_wake_filt.sv ***
/*
  Wake-up duration filter: one-cycle pulse once the input has stayed active
  for the minimum wake time.
  Assumes the input is synchronous to i_clk_sys.
*/
`timescale 1ns/10ps
module ftc_wake_filt (
	// clock and reset
	input  wire logic i_clk_sys,
	input  wire logic i_rst,
	// level in, accepted pulse out
	input  wire logic i_level,
	input  wire logic i_enable,
	output logic      o_wake
);

	localparam logic [ftc_pkg::WAKE_CW-1:0] LIMIT = ftc_pkg::WAKE_CW'(ftc_pkg::WAKE_CYC);

	logic [ftc_pkg::WAKE_CW-1:0] cnt_r;
	logic [ftc_pkg::WAKE_CW-1:0] cnt_nxt;
	logic                        wake_r;
	logic                        wake_nxt;

	always_comb begin
		cnt_nxt  = cnt_r;
		wake_nxt = 1'b0;
		if (!i_level || !i_enable) begin
			// any return to inactive restarts the count
			cnt_nxt = '0;
		end else if (cnt_r < LIMIT) begin
			cnt_nxt = cnt_r + 1'b1;
		end else if (cnt_r == LIMIT) begin
			// fires once, strictly longer than the minimum
			cnt_nxt  = cnt_r + 1'b1;
			wake_nxt = 1'b1;
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			cnt_r  <= '0;
			wake_r <= 1'b0;
		end else begin
			cnt_r  <= cnt_nxt;
			wake_r <= wake_nxt;
		end
	end

	assign o_wake = wake_r;

endmodule

// *** tb/ftc_host_model.sv ***
/*
  Host-side model: the controller that drives the two mode pins.
  Assumes bench requests change just after rising edges.
*/
`timescale 1ns/10ps
module ftc_host_model (
	// clock and reset
	input  wire logic i_clk_sys,
	input  wire logic i_rst,
	// requested mode
	input  wire logic i_req_ps,
	input  wire logic i_req_en,
	// mode pins
	output logic      o_power_mode_select,
	output logic      o_enable
);
	// pins move only right after an edge, so the design never sees a mid-cycle change
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_power_mode_select <= 1'b0;
			o_enable            <= 1'b0;
		end else begin
			o_power_mode_select <= i_req_ps;
			o_enable            <= i_req_en;
		end
	end
endmodule

// *** tb/ftc_mode_ctrl_checker.sv ***
/*
  Port-level properties of ftc_mode_ctrl.
  Assumes bus wake stays enabled whenever CANH is held dominant.
*/
`timescale 1ns/10ps
module ftc_mode_ctrl_checker (
	// clock and reset
	input wire logic       i_clk_sys,
	input wire logic       i_rst,
	// bus
	input wire logic       i_wb_cyc,
	input wire logic       i_wb_stb,
	input wire logic       o_wb_ack,
	// pins and front end
	input wire logic       i_power_mode_select,
	input wire logic       i_enable,
	input wire logic       i_vcc_ok,
	input wire logic       i_canh_dom,
	input wire logic       i_canl_dom,
	input wire logic       i_local_wake_n,
	input wire logic [3:0] i_fail_class,
	input wire logic       i_diff_restored,
	// outputs watched
	input wire logic       o_rx_data,
	input wire logic       o_fault_wake_flag_n,
	input wire logic       o_regulator_inhibit_out,
	input wire logic       o_regulator_inhibit_oe_n,
	input wire logic       o_high_term_on,
	input wire logic       o_low_term_on,
	input wire logic       o_low_term_to_batt,
	input wire logic       o_low_term_pullup_current_on,
	input wire logic       o_high_term_pd_sw,
	input wire logic       o_low_term_pu_sw,
	input wire logic       o_canh_drv_en,
	input wire logic       o_canl_drv_en,
	input wire logic       o_lp_fail_detect_en
);
	// ----------------------------------------
	// bus wake duration counter
	// ----------------------------------------
	logic [12:0] dom_cnt_r;
	logic [12:0] dom_cnt_nxt;
	always_comb begin
		dom_cnt_nxt = dom_cnt_r;
		if (!(i_canh_dom && !i_power_mode_select && !i_enable && i_vcc_ok)) begin
			dom_cnt_nxt = 13'h0;
		end else if (dom_cnt_r != 13'h1FFF) begin
			dom_cnt_nxt = dom_cnt_r + 13'h1;
		end
	end
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			dom_cnt_r <= 13'h0;
		end else begin
			dom_cnt_r <= dom_cnt_nxt;
		end
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);
	sequence s_normal;
		(i_power_mode_select && i_enable)[*3];
	endsequence
	sequence s_quiet_low;
		(!i_power_mode_select && !i_enable && !i_canh_dom && !i_canl_dom && i_local_wake_n)[*3];
	endsequence
	sequence s_sleep;
		(!i_power_mode_select && i_enable) ##1 s_quiet_low;
	endsequence
	a_wb_ack_next: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
		else $error("bus ack missing one cycle after request");
	a_wb_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("bus ack longer than one cycle");
	a_normal_links_on: assert property (s_normal and (i_fail_class == 4'h0 && i_diff_restored)[*3]
		|-> o_canh_drv_en && o_canl_drv_en && o_high_term_on && o_low_term_on && o_high_term_pd_sw && o_low_term_pu_sw)
		else $error("normal mode without failure not fully enabled");
	a_canh_fault_off: assert property ((i_fail_class == 4'h3 || i_fail_class == 4'h8)[*3]
		|-> !o_canh_drv_en && !o_high_term_on)
		else $error("high wire fault left high side on");
	a_canl_fault_off: assert property ((i_fail_class == 4'h4 || i_fail_class == 4'h7)[*3]
		|-> !o_canl_drv_en && !(o_low_term_on && o_low_term_pullup_current_on))
		else $error("low wire fault left low side on");
	a_canl_batt_mix: assert property (s_normal and (i_fail_class == 4'h6)[*3]
		|-> !o_low_term_on && o_high_term_on && o_canh_drv_en && o_canl_drv_en)
		else $error("low wire battery short handled wrongly");
	a_sleep_inh_hiz: assert property (s_sleep
		|-> o_regulator_inhibit_oe_n && o_low_term_to_batt && !o_high_term_pd_sw && !o_low_term_pu_sw)
		else $error("sleep outputs wrong");
	a_standby_inh_high: assert property (s_normal ##1 s_quiet_low
		|-> !o_regulator_inhibit_oe_n && o_regulator_inhibit_out && !o_canh_drv_en && o_lp_fail_detect_en
		&& o_rx_data && o_fault_wake_flag_n)
		else $error("standby after normal wrong");
	a_bus_wake_inh: assert property (dom_cnt_r == 13'hEE2
		|-> !o_regulator_inhibit_oe_n && o_regulator_inhibit_out && !o_fault_wake_flag_n && !o_rx_data)
		else $error("long bus dominance did not wake");
endmodule
bind ftc_mode_ctrl ftc_mode_ctrl_checker ftc_mode_ctrl_checker_i (.i_clk_sys, .i_rst, .i_wb_cyc, .i_wb_stb,
	.o_wb_ack, .i_power_mode_select, .i_enable, .i_vcc_ok, .i_canh_dom, .i_canl_dom, .i_local_wake_n,
	.i_fail_class, .i_diff_restored, .o_rx_data, .o_fault_wake_flag_n, .o_regulator_inhibit_out,
	.o_regulator_inhibit_oe_n, .o_high_term_on, .o_low_term_on, .o_low_term_to_batt,
	.o_low_term_pullup_current_on, .o_high_term_pd_sw, .o_low_term_pu_sw, .o_canh_drv_en, .o_canl_drv_en,
	.o_lp_fail_detect_en);

// *** tb/ftc_mode_ctrl_test.sv ***
/*
  Bench for ftc_mode_ctrl: host model on the mode pins, bus tasks, random failures.
  Assumes logic supply present until the last scenario.
*/
`timescale 1ns/10ps
module ftc_mode_ctrl_test;
	logic        i_clk_sys = 1'b0, i_rst = 1'b1, req_ps = 1'b0, req_en = 1'b0;
	logic        i_wb_cyc = 1'b0, i_wb_stb = 1'b0, i_wb_we = 1'b0;
	logic [3:0]  i_wb_adr = 4'h0, i_wb_sel = 4'hF, i_fail_class = 4'h0, v;
	logic [31:0] i_wb_dat = 32'h0, o_wb_dat, rd;
	logic        i_vcc_ok = 1'b1, i_battery_por = 1'b0, i_canh_dom = 1'b0, i_canl_dom = 1'b0;
	logic        i_local_wake_n = 1'b1, i_rx_data = 1'b1, i_diff_restored = 1'b1;
	logic        i_power_mode_select, i_enable, o_wb_ack, o_rx_data, o_fault_wake_flag_n;
	logic        o_regulator_inhibit_out, o_regulator_inhibit_oe_n, o_high_term_on, o_low_term_on;
	logic        o_low_term_to_batt, o_low_term_pullup_current_on, o_high_term_pd_sw, o_low_term_pu_sw;
	logic        o_canh_drv_en, o_canl_drv_en, o_lp_fail_detect_en;
	int          miscompares = 0, checks_done = 0;
	always #5 i_clk_sys = ~i_clk_sys;
	ftc_host_model ftc_host_model_i (.i_clk_sys, .i_rst, .i_req_ps(req_ps), .i_req_en(req_en),
		.o_power_mode_select(i_power_mode_select), .o_enable(i_enable));
	ftc_mode_ctrl ftc_mode_ctrl_i (.i_clk_sys, .i_rst, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel,
		.i_wb_dat, .o_wb_dat, .o_wb_ack, .i_power_mode_select, .i_enable, .i_vcc_ok, .i_battery_por,
		.i_canh_dom, .i_canl_dom, .i_local_wake_n, .i_rx_data, .i_fail_class, .i_diff_restored, .o_rx_data,
		.o_fault_wake_flag_n, .o_regulator_inhibit_out, .o_regulator_inhibit_oe_n, .o_high_term_on,
		.o_low_term_on, .o_low_term_to_batt, .o_low_term_pullup_current_on, .o_high_term_pd_sw,
		.o_low_term_pu_sw, .o_canh_drv_en, .o_canl_drv_en, .o_lp_fail_detect_en);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// {canh drv, canl drv, high term, low term} in normal mode
	function automatic logic [3:0] drv_exp(input logic [3:0] fc);
		case (fc)
			4'h3, 4'h8: drv_exp = 4'h5;
			4'h4, 4'h7: drv_exp = 4'hA;
			4'h6: drv_exp = 4'hE;
			default: drv_exp = 4'hF;
		endcase
	endfunction
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// ack is sampled at the edge; no fixed latency assumed
	task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge i_clk_sys);
		{i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat} <= {2'h3, we, adr, d};
		do begin
			@(posedge i_clk_sys);
			n++;
		end while (o_wb_ack !== 1'b1 && n < 20);
		q = o_wb_dat;
		{i_wb_cyc, i_wb_stb} <= 2'h0;
		if (n >= 20) chk("ack", 32'h0, 32'h1);
	endtask
	task automatic pins(input logic ps, input logic en);
		@(posedge i_clk_sys);
		{req_ps, req_en} <= {ps, en};
		repeat (4) @(posedge i_clk_sys);
		#1;
	endtask
	// src 0 CANH, 1 CANL, 2 local wake (active low)
	task automatic dom(input int n, input int src);
		@(posedge i_clk_sys);
		{i_local_wake_n, i_canl_dom, i_canh_dom} <= {src != 2, src == 1, src == 0};
		repeat (n) @(posedge i_clk_sys);
		{i_local_wake_n, i_canl_dom, i_canh_dom} <= 3'h4;
		repeat (3) @(posedge i_clk_sys);
		#1;
	endtask
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		#300000;
		miscompares++;
		report_and_stop;
	end
	initial begin
		void'($urandom(60));
		@(posedge i_clk_sys);
		#1;
		chk("rst pins", 32'({o_regulator_inhibit_oe_n, o_regulator_inhibit_out, o_rx_data,
			o_fault_wake_flag_n, o_lp_fail_detect_en}), 32'hF);
		@(posedge i_clk_sys);
		i_rst <= 1'b0;
		wb(1'b0, ftc_pkg::ADR_STATUS, 32'h0, rd);
		chk("status rst", rd & 32'h21F, 32'h213);
		wb(1'b0, ftc_pkg::ADR_CTRL, 32'h0, rd);
		chk("ctrl rst", rd & 32'h6, 32'h6);
		wb(1'b0, 4'hC, 32'h0, rd);
		chk("unmapped", rd, 32'h0);
		wb(1'b1, ftc_pkg::ADR_CTRL, 32'h7, rd);
		wb(1'b0, ftc_pkg::ADR_STATUS, 32'h0, rd);
		chk("por clr", rd & 32'h10, 32'h0);
		pins(1'b1, 1'b1);
		for (int i = 0; i < 20; i++) begin
			v = (i < 10) ? 4'(i) : 4'($urandom_range(9));
			@(posedge i_clk_sys);
			i_fail_class <= v;
			i_rx_data <= 1'($urandom);
			repeat (3) @(posedge i_clk_sys);
			#1;
			chk("rx", 32'(o_rx_data), 32'(i_rx_data));
			chk("drv", 32'({o_canh_drv_en, o_canl_drv_en, o_high_term_on, o_low_term_on}),
				32'(drv_exp(v)));
		end
		@(posedge i_clk_sys);
		{i_fail_class, i_diff_restored} <= {ftc_pkg::FAIL_CANH_VCC, 1'b0};
		repeat (3) @(posedge i_clk_sys);
		i_fail_class <= ftc_pkg::FAIL_NONE;
		repeat (3) @(posedge i_clk_sys);
		#1;
		chk("hold", 32'(o_fault_wake_flag_n), 32'h0);
		@(posedge i_clk_sys);
		i_diff_restored <= 1'b1;
		repeat (3) @(posedge i_clk_sys);
		#1;
		chk("release", 32'(o_fault_wake_flag_n), 32'h1);
		pins(1'b0, 1'b0);
		chk("standby", 32'({o_canh_drv_en, o_canl_drv_en, o_high_term_on, o_low_term_pullup_current_on,
			o_high_term_pd_sw, o_low_term_pu_sw, o_regulator_inhibit_oe_n, o_regulator_inhibit_out,
			o_lp_fail_detect_en}), 32'h7B);
		@(posedge i_clk_sys);
		i_battery_por <= 1'b1;
		@(posedge i_clk_sys);
		i_battery_por <= 1'b0;
		pins(1'b1, 1'b0);
		chk("por stby", 32'({o_fault_wake_flag_n, o_rx_data, o_regulator_inhibit_oe_n,
			o_regulator_inhibit_out}), 32'h5);
		pins(1'b0, 1'b1);
		pins(1'b0, 1'b0);
		dom(3790, 0);
		chk("sleep", 32'({o_regulator_inhibit_oe_n, o_low_term_to_batt, o_high_term_pd_sw, o_low_term_pu_sw,
			o_rx_data, o_fault_wake_flag_n}), 32'h33);
		pins(1'b1, 1'b0);
		chk("por from sleep", 32'(o_regulator_inhibit_oe_n), 32'h1);
		pins(1'b0, 1'b1);
		pins(1'b0, 1'b0);
		dom(3815, 0);
		chk("wake", 32'({o_regulator_inhibit_oe_n, o_regulator_inhibit_out, o_fault_wake_flag_n,
			o_rx_data}), 32'h4);
		wb(1'b0, ftc_pkg::ADR_STATUS, 32'h0, rd);
		chk("wake status", rd & 32'hF, 32'hB);
		pins(1'b1, 1'b1);
		wb(1'b0, ftc_pkg::ADR_STATUS, 32'h0, rd);
		chk("wake clr", rd & 32'h8, 32'h0);
		// two pulses that only add up past the limit must not wake
		pins(1'b0, 1'b0);
		dom(2000, 1);
		dom(2000, 1);
		chk("restart", 32'({o_rx_data, o_fault_wake_flag_n}), 32'h3);
		wb(1'b1, ftc_pkg::ADR_CTRL, 32'h2, rd);
		wb(1'b0, ftc_pkg::ADR_CTRL, 32'h0, rd);
		chk("ctrl wr", rd & 32'h6, 32'h2);
		dom(3815, 1);
		chk("bus wake off", 32'({o_rx_data, o_fault_wake_flag_n}), 32'h3);
		dom(3815, 2);
		chk("local wake", 32'({o_regulator_inhibit_oe_n, o_regulator_inhibit_out, o_fault_wake_flag_n,
			o_rx_data}), 32'h4);
		@(posedge i_clk_sys);
		i_vcc_ok <= 1'b0;
		repeat (3) @(posedge i_clk_sys);
		#1;
		chk("no supply", 32'({o_rx_data, o_fault_wake_flag_n}), 32'h3);
		report_and_stop;
	end
endmodule
